// >>> drive_guard_pkg.sv
package drive_guard_pkg;
  localparam int CLK_PERIOD_NS = 100;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
  localparam int BRAKE_MAX_S = 15;
  localparam int BRAKE_MAX_TICKS = BRAKE_MAX_S * (1000000000 / TICK_NS);
  localparam int AVG_WINDOW_S = 10;
  localparam int SAMPLE_TICKS = 100;
  localparam int AVG_SAMPLES = AVG_WINDOW_S * (1000000000 / TICK_NS) / SAMPLE_TICKS;
  localparam int DUTY_CYCLE_TICKS = 100;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int AIN_W = 12;
  localparam int FREQ_W = 16;
  localparam int EV_W = 3;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_LOSS_TIME = 8'h04;
  localparam logic [7:0] OFS_LOW_POINT = 8'h08;
  localparam logic [7:0] OFS_PRESET = 8'h0c;
  localparam logic [7:0] OFS_DUTY = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h18;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h1c;
  localparam logic [7:0] OFS_IRQ_EN = 8'h20;
  localparam logic [7:0] OFS_FREQ = 8'h24;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_SEL_BIT = 3;
  localparam int CTRL_LINK_BIT = 4;
  localparam int ST_LOSS_BIT = 0;
  localparam int ST_CUT_BIT = 1;
  localparam int ST_TRIP_BIT = 2;
  localparam int ST_BRAKE_BIT = 3;
  localparam logic [2:0] MODE_NONE = 3'h0;
  localparam logic [2:0] MODE_FREE_RUN = 3'h1;
  localparam logic [2:0] MODE_DEC = 3'h2;
  localparam logic [2:0] MODE_HOLD_IN = 3'h3;
  localparam logic [2:0] MODE_HOLD_OUT = 3'h4;
  localparam logic [2:0] MODE_PRESET = 3'h5;
  localparam logic [2:0] MODE_RST = 3'h0;
  localparam logic SEL_RST = 1'b0;
  localparam logic [15:0] LOSS_TIME_RST = 16'h03e8;
  localparam logic [AIN_W-1:0] LOW_POINT_RST = 12'h000;
  localparam logic [FREQ_W-1:0] PRESET_RST = 16'h0000;
  localparam logic [7:0] DUTY_RST = 8'h0a;
  localparam logic [7:0] DUTY_MAX = 8'h1e;
endpackage

// >>> loss_timer.sv
module loss_timer #(
  parameter int CNT_W = 16
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic tick,
  input wire logic hold,
  input wire logic [CNT_W-1:0] limit,
  output logic expired_r
);
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic expired_nxt;

  assign cnt_nxt = !hold ? '0 : ((tick && cnt_r < limit) ? cnt_r + 1'b1 : cnt_r);
  assign expired_nxt = hold && (cnt_nxt >= limit);

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= '0;
      expired_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      expired_r <= expired_nxt;
    end
  end

  AST_TIMER_RESTART: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !hold |=> (cnt_r == '0) && !expired_r) else $error("timer did not restart");
  AST_TIMER_FULL: assert property (@(posedge clk_sys) disable iff (!rst_b)
    $rose(expired_r) |-> $past(hold) && ($past(cnt_nxt) >= $past(limit)))
    else $error("loss declared before decision time");
endmodule // loss_timer

// >>> window_avg.sv
module window_avg #(
  parameter int WIDTH = 16,
  parameter int SAMPLES = 100
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic sample,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] avg_r
);
  localparam int SUM_W = WIDTH + $clog2(SAMPLES + 1);
  localparam int CNT_W = $clog2(SAMPLES + 1);
  localparam logic [16:0] RECIP = 17'(65536 / SAMPLES);
  logic [SUM_W-1:0] sum_r;
  logic [CNT_W-1:0] cnt_r;
  logic [SUM_W+16:0] prod;
  logic last;

  // average of the last complete window, reciprocal multiply
  assign last = sample && (cnt_r == CNT_W'(SAMPLES - 1));
  assign prod = (SUM_W + 17)'(sum_r + SUM_W'(din)) * (SUM_W + 17)'(RECIP);

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sum_r <= '0;
      cnt_r <= '0;
      avg_r <= '0;
    end else if (last) begin
      sum_r <= '0;
      cnt_r <= '0;
      avg_r <= prod[WIDTH+15:16];
    end else if (sample) begin
      sum_r <= sum_r + SUM_W'(din);
      cnt_r <= cnt_r + 1'b1;
    end
  end
endmodule // window_avg

// >>> drive_guard.sv
// How it works
// - reaction code 5 runs at the preset fallback frequency after loss
// - threshold select 0: loss when input below half low point for decision time
// - threshold select 1: loss when input below low point for decision time
// - link source: loss only after commands absent for the decision time
// - brake duty ratio percent register, 0 to 30, default 10, gates brake
// - brake drive stops after 15 seconds of continuous braking
// - brake resistor heat sensor input raises an external trip
// - code 0 passes through, 1 blocks output, 2 decelerates by trip time
// - codes 3 and 4 use 10 second input or output average
//
// The address map and strobed register access are this design's own decisions.
module drive_guard #(
  parameter int TICK_CYCLES = drive_guard_pkg::TICK_CYCLES,
  parameter int BRAKE_MAX_TICKS = drive_guard_pkg::BRAKE_MAX_TICKS
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [drive_guard_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [drive_guard_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [drive_guard_pkg::DATA_W-1:0] reg_rdata_r,
  input wire logic [drive_guard_pkg::AIN_W-1:0] ain,
  input wire logic link_cmd_valid,
  input wire logic [drive_guard_pkg::FREQ_W-1:0] link_cmd_freq,
  input wire logic [drive_guard_pkg::FREQ_W-1:0] out_freq,
  input wire logic brake_req,
  input wire logic heat_sensor,
  output logic [drive_guard_pkg::FREQ_W-1:0] freq_ref_r,
  output logic out_block_r,
  output logic decel_trip_r,
  output logic brake_drive_r,
  output logic ext_trip_r,
  output logic loss_warn_r,
  output logic brake_warn_r,
  output logic irq_r
);
  import drive_guard_pkg::*;

  localparam int TICK_W = $clog2(TICK_CYCLES + 1);
  localparam int BRK_W = $clog2(BRAKE_MAX_TICKS + 1);

  logic [2:0] mode_r;
  logic sel_r;
  logic link_src_r;
  logic [15:0] loss_time_r;
  logic [AIN_W-1:0] low_point_r;
  logic [FREQ_W-1:0] preset_r;
  logic [7:0] duty_r;
  logic [EV_W-1:0] irq_stat_r;
  logic [EV_W-1:0] irq_en_r;
  logic [TICK_W-1:0] tick_cnt_r;
  logic tick_r;
  logic [6:0] sample_cnt_r;
  logic sample_r;
  logic [6:0] phase_r;
  logic [BRK_W-1:0] brk_cnt_r;
  logic heat_s1_r;
  logic heat_s2_r;
  logic [FREQ_W-1:0] link_freq_r;
  logic [FREQ_W-1:0] hold_in_r;
  logic [FREQ_W-1:0] hold_out_r;
  logic loss_r;
  logic cut_r;

  logic wr_ctrl, wr_time, wr_low, wr_preset, wr_duty, wr_clr, wr_en;
  logic [AIN_W-1:0] threshold;
  logic an_below;
  logic loss_an;
  logic loss_link;
  logic loss_any;
  logic act;
  logic [FREQ_W-1:0] cmd_live;
  logic [FREQ_W-1:0] avg_in;
  logic [FREQ_W-1:0] avg_out;
  logic [FREQ_W-1:0] freq_ref_nxt;
  logic brk_cut;
  logic brake_nxt;
  logic [EV_W-1:0] events;
  logic [EV_W-1:0] irq_stat_nxt;
  logic [DATA_W-1:0] status;
  logic [DATA_W-1:0] rdata_nxt;
  logic [7:0] duty_wr;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  assign wr_ctrl = reg_wr && hit(reg_addr, OFS_CTRL);
  assign wr_time = reg_wr && hit(reg_addr, OFS_LOSS_TIME);
  assign wr_low = reg_wr && hit(reg_addr, OFS_LOW_POINT);
  assign wr_preset = reg_wr && hit(reg_addr, OFS_PRESET);
  assign wr_duty = reg_wr && hit(reg_addr, OFS_DUTY);
  assign wr_clr = reg_wr && hit(reg_addr, OFS_IRQ_CLR);
  assign wr_en = reg_wr && hit(reg_addr, OFS_IRQ_EN);

  assign duty_wr = (reg_wdata[7:0] > DUTY_MAX) ? DUTY_MAX : reg_wdata[7:0];

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mode_r <= MODE_RST;
      sel_r <= SEL_RST;
      link_src_r <= 1'b0;
      loss_time_r <= LOSS_TIME_RST;
      low_point_r <= LOW_POINT_RST;
      preset_r <= PRESET_RST;
      duty_r <= DUTY_RST;
      irq_en_r <= '0;
    end else begin
      if (wr_ctrl) begin
        mode_r <= reg_wdata[CTRL_MODE_LSB+:3];
        sel_r <= reg_wdata[CTRL_SEL_BIT];
        link_src_r <= reg_wdata[CTRL_LINK_BIT];
      end
      if (wr_time) loss_time_r <= reg_wdata;
      if (wr_low) low_point_r <= reg_wdata[AIN_W-1:0];
      if (wr_preset) preset_r <= reg_wdata;
      if (wr_duty) duty_r <= duty_wr;
      if (wr_en) irq_en_r <= reg_wdata[EV_W-1:0];
    end
  end

  // millisecond tick and 100 ms sample strobe
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      tick_cnt_r <= '0;
      tick_r <= 1'b0;
      sample_cnt_r <= '0;
      sample_r <= 1'b0;
      phase_r <= '0;
    end else begin
      tick_r <= (tick_cnt_r == TICK_W'(TICK_CYCLES - 1));
      tick_cnt_r <= (tick_cnt_r == TICK_W'(TICK_CYCLES - 1)) ? '0 : tick_cnt_r + 1'b1;
      sample_r <= tick_r && (sample_cnt_r == 7'(SAMPLE_TICKS - 1));
      if (tick_r) begin
        sample_cnt_r <= (sample_cnt_r == 7'(SAMPLE_TICKS - 1)) ? '0 : sample_cnt_r + 1'b1;
        phase_r <= (phase_r == 7'(DUTY_CYCLE_TICKS - 1)) ? '0 : phase_r + 1'b1;
      end
    end
  end

  assign threshold = sel_r ? low_point_r : (low_point_r >> 1);
  assign an_below = ain < threshold;

  loss_timer #(.CNT_W(16)) u_an_timer (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .tick(tick_r),
    .hold(an_below && !link_src_r),
    .limit(loss_time_r),
    .expired_r(loss_an)
  );

  loss_timer #(.CNT_W(16)) u_link_timer (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .tick(tick_r),
    .hold(!link_cmd_valid && link_src_r),
    .limit(loss_time_r),
    .expired_r(loss_link)
  );

  assign loss_any = link_src_r ? loss_link : loss_an;
  assign cmd_live = link_src_r ? link_freq_r : FREQ_W'(ain);

  window_avg #(.WIDTH(FREQ_W), .SAMPLES(AVG_SAMPLES)) u_avg_in (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .sample(sample_r),
    .din(cmd_live),
    .avg_r(avg_in)
  );

  window_avg #(.WIDTH(FREQ_W), .SAMPLES(AVG_SAMPLES)) u_avg_out (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .sample(sample_r),
    .din(out_freq),
    .avg_r(avg_out)
  );

  assign act = loss_r && (mode_r != MODE_NONE);

  always_comb begin
    freq_ref_nxt = cmd_live;
    if (act) begin
      case (mode_r)
        MODE_HOLD_IN: freq_ref_nxt = hold_in_r;
        MODE_HOLD_OUT: freq_ref_nxt = hold_out_r;
        MODE_PRESET: freq_ref_nxt = preset_r;
        default: freq_ref_nxt = cmd_live;
      endcase
    end
  end

  assign brk_cut = brk_cnt_r >= BRK_W'(BRAKE_MAX_TICKS);
  assign brake_nxt = brake_req && (phase_r < duty_r[6:0]) && !brk_cut;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      heat_s1_r <= 1'b0;
      heat_s2_r <= 1'b0;
      link_freq_r <= '0;
      hold_in_r <= '0;
      hold_out_r <= '0;
      loss_r <= 1'b0;
      cut_r <= 1'b0;
      brk_cnt_r <= '0;
      freq_ref_r <= '0;
      out_block_r <= 1'b0;
      decel_trip_r <= 1'b0;
      brake_drive_r <= 1'b0;
      ext_trip_r <= 1'b0;
      loss_warn_r <= 1'b0;
      brake_warn_r <= 1'b0;
    end else begin
      heat_s1_r <= heat_sensor;
      heat_s2_r <= heat_s1_r;
      if (link_cmd_valid) link_freq_r <= link_cmd_freq;
      if (loss_any && !loss_r) begin
        hold_in_r <= avg_in;
        hold_out_r <= avg_out;
      end
      loss_r <= loss_any;
      cut_r <= brk_cut;
      if (!brake_req) brk_cnt_r <= '0;
      else if (tick_r && !brk_cut) brk_cnt_r <= brk_cnt_r + 1'b1;
      freq_ref_r <= freq_ref_nxt;
      out_block_r <= act && (mode_r == MODE_FREE_RUN);
      decel_trip_r <= act && (mode_r == MODE_DEC);
      brake_drive_r <= brake_nxt;
      ext_trip_r <= heat_s2_r;
      loss_warn_r <= loss_any;
      brake_warn_r <= brk_cut;
    end
  end

  assign events = {heat_s2_r && !ext_trip_r, brk_cut && !cut_r, loss_any && !loss_r};
  assign irq_stat_nxt = (irq_stat_r & ~(wr_clr ? reg_wdata[EV_W-1:0] : '0)) | events;
  assign status = DATA_W'({brake_drive_r, ext_trip_r, cut_r, loss_r});
  assign rdata_nxt = !reg_rd ? '0 :
                     hit(reg_addr, OFS_CTRL) ? DATA_W'({link_src_r, sel_r, mode_r}) :
                     hit(reg_addr, OFS_LOSS_TIME) ? loss_time_r :
                     hit(reg_addr, OFS_LOW_POINT) ? DATA_W'(low_point_r) :
                     hit(reg_addr, OFS_PRESET) ? preset_r :
                     hit(reg_addr, OFS_DUTY) ? DATA_W'(duty_r) :
                     hit(reg_addr, OFS_STATUS) ? status :
                     hit(reg_addr, OFS_IRQ_STAT) ? DATA_W'(irq_stat_r) :
                     hit(reg_addr, OFS_IRQ_EN) ? DATA_W'(irq_en_r) :
                     hit(reg_addr, OFS_FREQ) ? freq_ref_r : '0;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      irq_stat_r <= '0;
      irq_r <= 1'b0;
      reg_rdata_r <= '0;
    end else begin
      irq_stat_r <= irq_stat_nxt;
      irq_r <= |(irq_stat_nxt & irq_en_r);
      reg_rdata_r <= rdata_nxt;
    end
  end

  AST_PRESET_RUN: assert property (@(posedge clk_sys) disable iff (!rst_b)
    loss_r && mode_r == MODE_PRESET |=> freq_ref_r == $past(preset_r))
    else $error("preset frequency not applied");
  AST_HALF_LEVEL: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !link_src_r && !sel_r && ain >= (low_point_r >> 1) |=> !loss_an)
    else $error("loss with input above half low point");
  AST_LOW_LEVEL: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !link_src_r && sel_r && ain >= low_point_r |=> !loss_an)
    else $error("loss with input above low point");
  AST_LINK_ALIVE: assert property (@(posedge clk_sys) disable iff (!rst_b)
    link_src_r && link_cmd_valid |=> !loss_link ##1 !loss_r)
    else $error("link loss despite valid command");
  AST_DUTY_GATE: assert property (@(posedge clk_sys) disable iff (!rst_b)
    brake_drive_r |-> $past(phase_r) < $past(duty_r[6:0]) && duty_r <= DUTY_MAX)
    else $error("brake outside duty window");
  AST_BRAKE_CAP: assert property (@(posedge clk_sys) disable iff (!rst_b)
    brake_drive_r |-> $past(brk_cnt_r) < BRK_W'(BRAKE_MAX_TICKS))
    else $error("brake past continuous limit");
  AST_HEAT_TRIP: assert property (@(posedge clk_sys) disable iff (!rst_b)
    heat_s2_r |=> ext_trip_r ##0 irq_stat_r[2] || $past(ext_trip_r))
    else $error("heat sensor trip missed");
  AST_FREE_RUN: assert property (@(posedge clk_sys) disable iff (!rst_b)
    loss_r && mode_r == MODE_FREE_RUN |=> out_block_r && !decel_trip_r)
    else $error("output not blocked");
  AST_NO_PROTECT: assert property (@(posedge clk_sys) disable iff (!rst_b)
    mode_r == MODE_NONE |=> !out_block_r && !decel_trip_r && freq_ref_r == $past(cmd_live))
    else $error("protection active in pass mode");
  AST_HOLD_IN: assert property (@(posedge clk_sys) disable iff (!rst_b)
    loss_any && !loss_r && mode_r == MODE_HOLD_IN ##1 mode_r == MODE_HOLD_IN && loss_r
    |=> freq_ref_r == $past(avg_in, 2))
    else $error("held input average not used");
endmodule // drive_guard

// >>> cmd_source.sv
module cmd_source (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [drive_guard_pkg::AIN_W-1:0] level,
  input wire logic link_on,
  output logic [drive_guard_pkg::AIN_W-1:0] ain,
  output logic link_cmd_valid,
  output logic [drive_guard_pkg::FREQ_W-1:0] link_cmd_freq
);
  timeunit 1ns;
  timeprecision 1ns;
  import drive_guard_pkg::*;
  logic [3:0] gap_r;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      gap_r <= 4'h0;
    end else begin
      gap_r <= (gap_r == 4'h9) ? 4'h0 : gap_r + 4'h1;
    end
  end
  assign link_cmd_valid = link_on && gap_r == 4'h0;
  assign link_cmd_freq = link_cmd_valid ? 16'h0321 : 16'hfcde;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ain <= '0;
    end else begin
      ain <= level;
    end
  end
endmodule // cmd_source

// >>> testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import drive_guard_pkg::*;
  typedef struct {logic w; logic [7:0] a; logic [15:0] d; logic [15:0] e;} reg_row_t;
  typedef struct {logic [7:0] c; logic [11:0] a; logic l; logic fc; logic [15:0] f;
    logic [1:0] bd;} ana_row_t;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic brake_req = 1'b0;
  logic heat_sensor = 1'b0;
  logic link_on = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] out_freq = 16'h0300;
  logic [11:0] lvl = 12'h200;
  logic link_cmd_valid, out_block_r, decel_trip_r, brake_drive_r, ext_trip_r;
  logic loss_warn_r, brake_warn_r, irq_r;
  logic [15:0] reg_rdata_r, link_cmd_freq, freq_ref_r, rv;
  logic [11:0] ain;
  int n_errors = 0;
  int compares = 0;
  int hi = 0;
  reg_row_t regs [16] = '{'{0, OFS_CTRL, 0, 0}, '{0, OFS_LOSS_TIME, 0, 16'h03e8},
    '{0, OFS_LOW_POINT, 0, 0}, '{0, OFS_PRESET, 0, 0}, '{0, OFS_DUTY, 0, 16'h000a},
    '{0, OFS_IRQ_EN, 0, 0}, '{0, 8'h30, 0, 0}, '{1, OFS_DUTY, 16'h001e, 16'h001e},
    '{1, OFS_DUTY, 16'h001f, 16'h001e}, '{1, OFS_DUTY, 16'h0000, 16'h0000},
    '{1, OFS_STATUS, 16'hffff, 0}, '{1, 8'h30, 16'h5555, 0},
    '{1, OFS_LOW_POINT, 16'hffff, 16'h0fff}, '{1, OFS_LOW_POINT, 16'h0000, 0},
    '{1, OFS_PRESET, 16'h1234, 16'h1234}, '{1, OFS_FREQ, 16'h1111, 16'h0200}};
  ana_row_t ana [8] = '{'{8'h05, 12'h080, 0, 1, 16'h0080, 2'b00},
    '{8'h05, 12'h07f, 1, 1, 16'h1234, 2'b00}, '{8'h0d, 12'h100, 0, 1, 16'h0100, 2'b00},
    '{8'h0d, 12'h0ff, 1, 1, 16'h1234, 2'b00}, '{8'h09, 12'h0ff, 1, 0, 16'h0000, 2'b10},
    '{8'h0a, 12'h0ff, 1, 0, 16'h0000, 2'b01}, '{8'h08, 12'h0ff, 1, 1, 16'h00ff, 2'b00},
    '{8'h0e, 12'h0ff, 1, 1, 16'h00ff, 2'b00}};

  drive_guard #(.TICK_CYCLES(4), .BRAKE_MAX_TICKS(20)) i_drive_guard (
    .clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .ain(ain),
    .link_cmd_valid(link_cmd_valid), .link_cmd_freq(link_cmd_freq), .out_freq(out_freq),
    .brake_req(brake_req), .heat_sensor(heat_sensor), .freq_ref_r(freq_ref_r),
    .out_block_r(out_block_r), .decel_trip_r(decel_trip_r), .brake_drive_r(brake_drive_r),
    .ext_trip_r(ext_trip_r), .loss_warn_r(loss_warn_r), .brake_warn_r(brake_warn_r),
    .irq_r(irq_r));
  cmd_source i_cmd_source (.clk_sys(clk_sys), .rst_b(rst_b), .level(lvl), .link_on(link_on),
    .ain(ain), .link_cmd_valid(link_cmd_valid), .link_cmd_freq(link_cmd_freq));

  initial begin
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic give_verdict();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(input string s, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", s, exp, seen);
    end
  endtask

  task automatic done(input string s);
    $display("test %s done", s);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata_r;
  endtask

  function automatic logic pick(input int sel);
    case (sel)
      0: return loss_warn_r;
      1: return brake_warn_r;
      2: return ext_trip_r;
      3: return irq_r;
      default: return link_cmd_valid;
    endcase
  endfunction

  task automatic wait_for(input int sel, input logic v, input int n);
    int i;
    for (i = 0; i < n && pick(sel) !== v; i++) begin
      @(posedge clk_sys);
      #1;
    end
    check("wait", pick(sel), v);
    if (pick(sel) !== v) give_verdict();
  endtask

  task automatic burst(input int n);
    @(posedge clk_sys);
    brake_req <= 1'b1;
    repeat (n) begin
      @(posedge clk_sys);
      #1;
      hi += int'(brake_drive_r === 1'b1);
    end
    @(posedge clk_sys);
    brake_req <= 1'b0;
  endtask

  initial begin
    @(posedge clk_sys);
    #1;
    check("reset", {freq_ref_r, out_block_r, decel_trip_r, brake_drive_r, ext_trip_r,
      loss_warn_r, brake_warn_r, irq_r}, 0);
    @(posedge clk_sys);
    rst_b <= 1'b1;
    foreach (regs[i]) begin
      if (regs[i].w) wr(regs[i].a, regs[i].d);
      rd(regs[i].a, rv);
      check("reg", rv, regs[i].e);
    end
    done("registers");
    cyc(42000);
    wr(OFS_LOSS_TIME, 16'h0005);
    wr(OFS_LOW_POINT, 16'h0100);
    wr(OFS_CTRL, 16'h000b);
    lvl <= 12'h0ff;
    wait_for(0, 1'b1, 40);
    cyc(3);
    #1;
    check("avg in", freq_ref_r inside {[16'h01f8:16'h0200]}, 1);
    wr(OFS_CTRL, 16'h000c);
    cyc(3);
    #1;
    check("avg out", freq_ref_r inside {[16'h02f8:16'h0300]}, 1);
    done("averages");
    foreach (ana[i]) begin
      @(posedge clk_sys);
      lvl <= 12'h800;
      cyc(4);
      wr(OFS_CTRL, {8'h00, ana[i].c});
      lvl <= ana[i].a;
      if (ana[i].l) wait_for(0, 1'b1, 40); else cyc(40);
      cyc(3);
      #1;
      check("loss", loss_warn_r, ana[i].l);
      if (ana[i].fc) check("freq", freq_ref_r, ana[i].f);
      check("blk dec", {out_block_r, decel_trip_r}, ana[i].bd);
    end
    done("analog");
    @(posedge clk_sys);
    lvl <= 12'h800;
    cyc(4);
    wr(OFS_CTRL, 16'h000d);
    lvl <= 12'h0ff;
    cyc(14);
    lvl <= 12'h800;
    cyc(2);
    lvl <= 12'h0ff;
    cyc(14);
    #1;
    check("restart", loss_warn_r, 0);
    wait_for(0, 1'b1, 20);
    @(posedge clk_sys);
    lvl <= 12'h800;
    wait_for(0, 1'b0, 6);
    done("restart");
    wr(OFS_CTRL, 16'h0015);
    link_on <= 1'b1;
    cyc(60);
    #1;
    check("link run", {loss_warn_r, freq_ref_r}, 17'h00321);
    wait_for(4, 1'b1, 12);
    @(posedge clk_sys);
    link_on <= 1'b0;
    cyc(14);
    #1;
    check("link gap", loss_warn_r, 0);
    wait_for(0, 1'b1, 20);
    cyc(3);
    #1;
    check("link lost", freq_ref_r, 16'h1234);
    @(posedge clk_sys);
    link_on <= 1'b1;
    wait_for(0, 1'b0, 15);
    done("link");
    burst(60);
    check("duty 0", hi, 0);
    wr(OFS_DUTY, 16'h001e);
    repeat (7) burst(60);
    check("duty 30", hi inside {[96:150]}, 1);
    @(posedge clk_sys);
    brake_req <= 1'b1;
    cyc(70);
    #1;
    check("brake early", brake_warn_r, 0);
    wait_for(1, 1'b1, 20);
    cyc(1);
    #1;
    check("brake cut", brake_drive_r, 0);
    rd(OFS_STATUS, rv);
    check("status", rv, 16'h0002);
    rd(OFS_IRQ_STAT, rv);
    check("irq events", rv, 16'h0003);
    @(posedge clk_sys);
    brake_req <= 1'b0;
    done("brake");
    wr(OFS_IRQ_CLR, 16'h0007);
    heat_sensor <= 1'b1;
    wait_for(2, 1'b1, 6);
    rd(OFS_IRQ_STAT, rv);
    check("irq stat", {rv, irq_r}, 17'h00008);
    rd(OFS_STATUS, rv);
    check("trip status", rv, 16'h0004);
    wr(OFS_IRQ_EN, 16'h0004);
    wait_for(3, 1'b1, 4);
    wr(OFS_IRQ_CLR, 16'h0004);
    wait_for(3, 1'b0, 4);
    @(posedge clk_sys);
    heat_sensor <= 1'b0;
    wait_for(2, 1'b0, 6);
    rd(OFS_IRQ_STAT, rv);
    check("irq clr", rv, 0);
    done("irq");
    @(posedge clk_sys);
    rst_b <= 1'b0;
    cyc(2);
    #1;
    check("rst out", {freq_ref_r, ext_trip_r, loss_warn_r, irq_r}, 0);
    @(posedge clk_sys);
    rst_b <= 1'b1;
    rd(OFS_DUTY, rv);
    check("rst duty", rv, 16'h000a);
    done("reset");
    give_verdict();
  end
endmodule // testbench
